// ---- hdl/flag_cell.sv ----
// Purpose: one retained cause flag with hardware and firmware update
// Assumes: init, hw_event and sw_write are one-cycle strobes
// Notes:   init beats the event, the event beats firmware
`timescale 1ns/1ps
module flag_cell #(
    parameter logic RESET_VAL = 1'b0,
    parameter logic HW_VAL = 1'b0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // updates
    input wire logic init,
    input wire logic hw_event,
    input wire logic sw_write,
    input wire logic sw_value,
    // flag
    output logic value
);

    typedef struct packed {
        logic value;
    } cell_state_t;

    cell_state_t state_r;
    cell_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (init) begin
            state_nxt.value = RESET_VAL;
        end else if (hw_event) begin
            // an event in the cycle of a firmware write is lost only to init
            state_nxt.value = HW_VAL;
        end else if (sw_write) begin
            state_nxt.value = sw_value;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '{value: RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value = state_r.value;

    a_event_beats_write: assert property (
        @(posedge clock) disable iff (!reset_n)
        (hw_event && !init) |=> (value == HW_VAL))
        else $error("flag missed its hardware event");

endmodule // flag_cell

// ---- hdl/reset_cause_status.sv ----
// Purpose: reset cause status register with event interrupt
// Assumes: event inputs are one-cycle strobes synchronous to clock
// Notes:   reset_n is the power-on reset; other resets arrive as
//          strobes so the flags survive them
//
// What this block does
// - stack overflow sets bit 7; it stays set until firmware writes zero.
// - stack underflow sets bit 6; it stays set until firmware clears it.
// - watchdog window violation clears bit 5; firmware may write one.
// - watchdog timeout reset clears bit 4; otherwise reads one or written.
// - external reset pin reset clears bit 3; otherwise one or written.
// - reset instruction clears bit 2; otherwise one or written one.
// - power-on reset drives bit 1 low; firmware sets it afterwards.
// - brown-out reset drives bit 0 low; firmware sets it afterwards.
// - power-on gives stack flags zero and bits 5 to 2 one.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module reset_cause_status #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // event strobes
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_window_armed,
    input wire logic watchdog_window_open,
    input wire logic watchdog_timeout,
    input wire logic external_reset_pin,
    input wire logic reset_instruction,
    input wire logic power_on_event,
    input wire logic brownout_event,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // status
    output logic [7:0] cause,
    output logic irq
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] evt_status;
        logic [7:0] evt_mask;
        logic irq;
    } slave_state_t;

    slave_state_t st_r;
    slave_state_t st_nxt;

    logic [7:0] events;
    logic window_violation;
    logic wr_fire;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic cause_we;
    logic [7:0] cause_hw;

    // ************************************************************
    // event collection
    // ************************************************************
    // a clear without arming, or outside the window, is a violation
    assign window_violation = watchdog_clear_instruction &&
        (!watchdog_window_armed || !watchdog_window_open);

    always_comb begin
        events = 8'h00;
        events[reset_cause_pkg::BIT_STACK_OVERFLOW] = stack_overflow;
        events[reset_cause_pkg::BIT_STACK_UNDERFLOW] = stack_underflow;
        events[reset_cause_pkg::BIT_WINDOW_VIOLATION] = window_violation;
        events[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT] = watchdog_timeout;
        events[reset_cause_pkg::BIT_EXTERNAL_PIN] = external_reset_pin;
        events[reset_cause_pkg::BIT_RESET_INSTRUCTION] = reset_instruction;
        events[reset_cause_pkg::BIT_POWER_ON] = power_on_event;
        events[reset_cause_pkg::BIT_BROWNOUT] = brownout_event;
    end

    // ************************************************************
    // bus handshakes
    // ************************************************************
    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready = !st_r.w_got && !st_r.bvalid;
    assign arready = !st_r.rvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign ar_take = arvalid && arready;
    // a write commits one cycle after both halves are held
    assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign cause_we = wr_fire && st_r.w_lane0 &&
        (st_r.aw_addr == ADDR_W'(reset_cause_pkg::ADDR_CAUSE));

    always_comb begin
        st_nxt = st_r;
        if (aw_take) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (w_take) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = wdata[7:0];
            st_nxt.w_lane0 = wstrb[0];
        end
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = reset_cause_pkg::RESP_OKAY;
            if (st_r.aw_addr == ADDR_W'(reset_cause_pkg::ADDR_EVT_MASK)) begin
                if (st_r.w_lane0) begin
                    st_nxt.evt_mask = st_r.w_data;
                end
            end else if ((st_r.aw_addr !=
                ADDR_W'(reset_cause_pkg::ADDR_CAUSE)) &&
                (st_r.aw_addr !=
                ADDR_W'(reset_cause_pkg::ADDR_EVT_STATUS))) begin
                st_nxt.bresp = reset_cause_pkg::RESP_SLVERR;
            end
        end else if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = reset_cause_pkg::RESP_OKAY;
            st_nxt.rdata = reset_cause_pkg::RDATA_RST;
            unique case (araddr)
                ADDR_W'(reset_cause_pkg::ADDR_CAUSE): begin
                    st_nxt.rdata[7:0] = cause;
                end
                ADDR_W'(reset_cause_pkg::ADDR_EVT_STATUS): begin
                    st_nxt.rdata[7:0] = st_r.evt_status;
                    // read clears; events below still win
                    st_nxt.evt_status = st_r.evt_status &
                        ~st_r.evt_status;
                end
                ADDR_W'(reset_cause_pkg::ADDR_EVT_MASK): begin
                    st_nxt.rdata[7:0] = st_r.evt_mask;
                end
                default: begin
                    st_nxt.rresp = reset_cause_pkg::RESP_SLVERR;
                end
            endcase
        end
        st_nxt.evt_status = st_nxt.evt_status | events;
        st_nxt.irq = |(st_nxt.evt_status & st_nxt.evt_mask);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{
                aw_got: 1'b0,
                aw_addr: '0,
                w_got: 1'b0,
                w_data: 8'h00,
                w_lane0: 1'b0,
                bvalid: 1'b0,
                bresp: reset_cause_pkg::RESP_OKAY,
                rvalid: 1'b0,
                rdata: reset_cause_pkg::RDATA_RST,
                rresp: reset_cause_pkg::RESP_OKAY,
                evt_status: reset_cause_pkg::EVT_STATUS_RST,
                evt_mask: reset_cause_pkg::EVT_MASK_RST,
                irq: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign irq = st_r.irq;

    // ************************************************************
    // cause flags
    // ************************************************************
    // power-on is not the only init path: a power-on strobe seen
    // while reset_n stays high reloads the same pattern
    assign cause_hw = events &
        ~(8'h01 << reset_cause_pkg::BIT_POWER_ON);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            flag_cell #(
                .RESET_VAL(reset_cause_pkg::CAUSE_POR_VAL[gi]),
                .HW_VAL(reset_cause_pkg::CAUSE_HW_VAL[gi])
            ) u_flag (
                .clock(clock),
                .reset_n(reset_n),
                .init(power_on_event),
                .hw_event(cause_hw[gi]),
                .sw_write(cause_we),
                .sw_value(st_r.w_data[gi]),
                .value(cause[gi])
            );
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_ovf_sets: assert property (
        stack_overflow && !power_on_event |=> cause[7] ##1
        (cause[7] || $past(cause_we) || $past(power_on_event)))
        else $error("overflow flag not set or not held");

    a_ovf_holds: assert property (
        cause[7] && !cause_we && !power_on_event |=> cause[7])
        else $error("overflow flag dropped without a write");

    a_unf_sets: assert property (
        stack_underflow && !power_on_event |=> cause[6])
        else $error("underflow flag not set");

    a_wv_clears: assert property (
        watchdog_clear_instruction && !watchdog_window_armed &&
        !power_on_event |=> !cause[5])
        else $error("window violation flag not cleared");

    a_wdt_clears: assert property (
        watchdog_timeout && !power_on_event |=> !cause[4])
        else $error("watchdog timeout flag not cleared");

    a_pin_clears: assert property (
        external_reset_pin && !power_on_event |=> !cause[3])
        else $error("external pin flag not cleared");

    a_ri_clears: assert property (
        reset_instruction && !power_on_event |=> !cause[2])
        else $error("reset instruction flag not cleared");

    a_por_pattern: assert property (
        power_on_event |=> cause == reset_cause_pkg::CAUSE_POR_VAL)
        else $error("power-on pattern wrong");

    a_por_bit_low: assert property (
        power_on_event |=> !cause[1] && !cause[0])
        else $error("power-on status not low");

    a_bor_low: assert property (
        brownout_event && !power_on_event |=> !cause[0])
        else $error("brown-out status not low");

    a_write_loses: assert property (
        cause_we && stack_overflow && !power_on_event && !st_r.w_data[7]
        |=> cause[7])
        else $error("firmware write beat the overflow event");

    a_wr_applies: assert property (
        cause_we && (events == 8'h00) |=> cause == $past(st_r.w_data))
        else $error("cause write not stored");

    a_irq_level: assert property (
        (st_r.evt_status & st_r.evt_mask) != 8'h00 |-> irq)
        else $error("interrupt low with unmasked status");

    a_bvalid_holds: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    a_unf_holds: assert property (
        cause[6] && !cause_we && !power_on_event |=> cause[6])
        else $error("underflow flag dropped without a write");

    a_wv_no_false: assert property (
        cause[5] && !window_violation && !cause_we |=> cause[5])
        else $error("window violation flag cleared without cause");

    a_wdt_no_false: assert property (
        cause[4] && !watchdog_timeout && !cause_we |=> cause[4])
        else $error("watchdog timeout flag cleared without cause");

    a_pin_no_false: assert property (
        cause[3] && !external_reset_pin && !cause_we |=> cause[3])
        else $error("external pin flag cleared without cause");

    a_ri_no_false: assert property (
        cause[2] && !reset_instruction && !cause_we |=> cause[2])
        else $error("reset instruction flag cleared without cause");

    a_status_sticky: assert property (
        1'b1 |=> (st_r.evt_status & $past(events)) == $past(events))
        else $error("event did not set its status bit");

    a_status_read_clr: assert property (
        ar_take && (araddr == ADDR_W'(reset_cause_pkg::ADDR_EVT_STATUS))
        |=> st_r.evt_status == $past(events))
        else $error("status read did not clear");

    a_rvalid_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped early");

    a_read_answer: assert property (
        ar_take |=> rvalid)
        else $error("read answer missing");

    c_cause_write: cover property (cause_we ##1 bvalid && bready);
    c_status_read: cover property (
        ar_take && (araddr == ADDR_W'(reset_cause_pkg::ADDR_EVT_STATUS)));
    c_irq_rise: cover property ($rose(irq));
    c_event_on_write: cover property (cause_we && events != 8'h00);

endmodule // reset_cause_status

// ---- include/reset_cause_pkg.sv ----
// Purpose: shared constants for the reset cause status block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit cause register
// Notes:   offsets are byte addresses, one aligned word each
package reset_cause_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] ADDR_CAUSE = 12'h000;
    localparam logic [11:0] ADDR_EVT_STATUS = 12'h004;
    localparam logic [11:0] ADDR_EVT_MASK = 12'h008;

    // ************************************************************
    // cause register field positions
    // ************************************************************
    localparam int BIT_STACK_OVERFLOW = 7;
    localparam int BIT_STACK_UNDERFLOW = 6;
    localparam int BIT_WINDOW_VIOLATION = 5;
    localparam int BIT_WATCHDOG_TIMEOUT = 4;
    localparam int BIT_EXTERNAL_PIN = 3;
    localparam int BIT_RESET_INSTRUCTION = 2;
    localparam int BIT_POWER_ON = 1;
    localparam int BIT_BROWNOUT = 0;

    // ************************************************************
    // values after reset and hardware update values
    // ************************************************************
    // power-on pattern: stack flags low, source flags high, por/bor low
    localparam logic [7:0] CAUSE_POR_VAL = 8'h3c;
    // value each bit takes when its own event fires
    localparam logic [7:0] CAUSE_HW_VAL = 8'hc0;
    localparam logic [7:0] EVT_STATUS_RST = 8'h00;
    localparam logic [7:0] EVT_MASK_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ************************************************************
    // bus responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- test/tb.sv ----
// Purpose: self-checking bench for the reset cause status block
// Assumes: axi4-lite master driven from here, 40 MHz clock
// Notes:   expected read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module tb;
    logic clock;
    logic reset_n;
    logic [7:0] evt;
    logic win_armed, win_open;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, strb;
    logic [1:0] bresp, rresp;
    logic [7:0] cause, exp_cause, exp_stat;
    logic [33:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;

    reset_cause_status reset_cause_status_inst (
        .clock(clock), .reset_n(reset_n),
        .stack_overflow(evt[7]), .stack_underflow(evt[6]),
        .watchdog_clear_instruction(evt[5]),
        .watchdog_window_armed(win_armed), .watchdog_window_open(win_open),
        .watchdog_timeout(evt[4]), .external_reset_pin(evt[3]),
        .reset_instruction(evt[2]), .power_on_event(evt[1]),
        .brownout_event(evt[0]),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .cause(cause), .irq(irq));

    // ********************************************************
    // checking and reference model
    // ********************************************************
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic model(input logic [7:0] e);
        exp_stat = exp_stat | e;
        // power-on reload wins over every other update
        exp_cause = e[1] ? reset_cause_pkg::CAUSE_POR_VAL
            : (exp_cause | (e & 8'hc0)) & ~(e & 8'h3d);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ********************************************************
    // bus tasks
    // ********************************************************
    // ev is pulsed so that it lands on the same edge as the write commit
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
        input logic [7:0] ev, input logic [1:0] er);
        logic ad, wd, ta, tw, bv;
        logic [1:0] br;
        ad = 0;
        wd = 0;
        bv = 0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= strb;
        bready <= 1'b1;
        while (!bv) begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            bv = bvalid;
            br = bresp;
            @(posedge clock);
            evt <= (!(ad && wd) && (ad || ta) && (wd || tw)) ? ev : 8'h00;
            ad = ad || ta;
            wd = wd || tw;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (a == reset_cause_pkg::ADDR_CAUSE && er == 2'b00 && strb[0])
            exp_cause = v[7:0];
        model(ev);
        check({32'h0, br}, {32'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] v,
        input logic [1:0] er);
        logic ta, rv;
        rv = 0;
        exp_q.push_back({er, v});
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        while (!rv) begin
            @(negedge clock);
            ta = arvalid && arready;
            rv = rvalid;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] v);
        logic [7:0] e;
        e = v;
        // a clear inside an armed, open window is no violation
        if (win_armed && win_open) e[5] = 1'b0;
        @(posedge clock);
        evt <= v;
        @(posedge clock);
        evt <= 8'h00;
        model(e);
    endtask

    always @(negedge clock) begin
        if (reset_n && rvalid && rready) begin
            if (exp_q.size() == 0) num_errors++;
            else check({rresp, rdata}, exp_q.pop_front());
        end
    end

    // ********************************************************
    // clock, watchdog and tests
    // ********************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        evt = 8'h00;
        win_armed = 1'b1;
        win_open = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        strb = 4'h1;
        exp_cause = reset_cause_pkg::CAUSE_POR_VAL;
        exp_stat = 8'h00;
        d = $urandom(32'hdb56a460);
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd(reset_cause_pkg::ADDR_CAUSE, 32'h3c, 2'b00);
        rd(reset_cause_pkg::ADDR_EVT_MASK, 32'h0, 2'b00);
        $display("test reset values finished");
        win_armed <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i == 1) continue;
            d = $urandom;
            d[i] = (i < 6);
            wr(reset_cause_pkg::ADDR_CAUSE, d, 8'h00, 2'b00);
            pulse(8'h01 << i);
            rd(reset_cause_pkg::ADDR_CAUSE, {24'h0, exp_cause},
                2'b00);
            rd(reset_cause_pkg::ADDR_EVT_STATUS, {24'h0, exp_stat}, 2'b00);
            exp_stat = 8'h00;
        end
        pulse(8'h02);
        rd(reset_cause_pkg::ADDR_CAUSE, 32'h3c, 2'b00);
        $display("test each event finished");
        for (int k = 0; k < 4; k++) begin
            win_armed <= k[1];
            win_open <= k[0];
            wr(reset_cause_pkg::ADDR_CAUSE, 32'hff, 8'h00, 2'b00);
            pulse(8'h20);
            rd(reset_cause_pkg::ADDR_CAUSE, {24'h0, exp_cause}, 2'b00);
            rd(reset_cause_pkg::ADDR_EVT_STATUS, {24'h0, exp_stat}, 2'b00);
            exp_stat = 8'h00;
        end
        $display("test window violation finished");
        wr(reset_cause_pkg::ADDR_CAUSE, 32'h00, 8'h80, 2'b00);
        wr(reset_cause_pkg::ADDR_CAUSE, 32'hff, 8'h10, 2'b00);
        rd(reset_cause_pkg::ADDR_CAUSE, 32'hef, 2'b00);
        rd(reset_cause_pkg::ADDR_EVT_STATUS, {24'h0, exp_stat}, 2'b00);
        exp_stat = 8'h00;
        $display("test event beats write finished");
        wr(reset_cause_pkg::ADDR_EVT_MASK, 32'h08, 8'h00, 2'b00);
        rd(reset_cause_pkg::ADDR_EVT_MASK, 32'h08, 2'b00);
        pulse(8'h04);
        @(negedge clock);
        check({33'h0, irq}, 34'h0);
        pulse(8'h08);
        @(negedge clock);
        check({33'h0, irq}, 34'h1);
        rd(reset_cause_pkg::ADDR_EVT_STATUS, 32'h0c, 2'b00);
        @(negedge clock);
        check({33'h0, irq}, 34'h0);
        wr(reset_cause_pkg::ADDR_EVT_STATUS, 32'hff, 8'h00, 2'b00);
        rd(reset_cause_pkg::ADDR_EVT_STATUS, 32'h0, 2'b00);
        exp_stat = 8'h00;
        wr(12'h00c, 32'hff, 8'h00, 2'b10);
        rd(12'h00c, 32'h0, 2'b10);
        $display("test interrupt and map finished");
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        check({26'h0, cause}, 34'h3c);
        rd(reset_cause_pkg::ADDR_CAUSE, 32'h3c, 2'b00);
        // a write with lane 0 off must leave the flags alone
        strb = 4'h0;
        wr(reset_cause_pkg::ADDR_CAUSE, 32'hff, 8'h00, 2'b00);
        rd(reset_cause_pkg::ADDR_CAUSE, 32'h3c, 2'b00);
        $display("test second reset finished");
        repeat (4) @(posedge clock);
        conclude();
    end
endmodule // tb
